//--- tmr_pkg.sv
// Package for the sixteen-bit capture/compare timer: register indices, field positions,
// reset values and the bus/pin carrier structs.
// Assumes a 32-bit APB slave where each byte register sits in the low byte of one word.
package tmr_pkg;
	// -----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// -----------------------------------------------------------------
	localparam logic [7:0] IDX_CTL_TWO = 8'h51;
	localparam logic [7:0] IDX_CTL_ONE = 8'h52;
	localparam logic [7:0] IDX_FLAGS = 8'h53;
	localparam logic [7:0] IDX_CAP1_HI = 8'h54;
	localparam logic [7:0] IDX_CAP1_LO = 8'h55;
	localparam logic [7:0] IDX_CMP1_HI = 8'h56;
	localparam logic [7:0] IDX_CMP1_LO = 8'h57;
	localparam logic [7:0] IDX_CNT_HI = 8'h58;
	localparam logic [7:0] IDX_CNT_LO = 8'h59;
	localparam logic [7:0] IDX_ACNT_HI = 8'h5a;
	localparam logic [7:0] IDX_ACNT_LO = 8'h5b;
	localparam logic [7:0] IDX_CAP2_HI = 8'h5c;
	localparam logic [7:0] IDX_CAP2_LO = 8'h5d;
	localparam logic [7:0] IDX_CMP2_HI = 8'h5e;
	localparam logic [7:0] IDX_CMP2_LO = 8'h5f;
	// Wake index of our own: accepted without a bus error, but no register sits behind it and it reads zero.
	localparam logic [7:0] IDX_WAKE = 8'h60;

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int C1_CAP_IE = 7;
	localparam int C1_CMP_IE = 6;
	localparam int C1_OVF_IE = 5;
	localparam int C1_FORCE2 = 4;
	localparam int C1_FORCE1 = 3;
	localparam int C1_LVL2 = 2;
	localparam int C1_EDGE1 = 1;
	localparam int C1_LVL1 = 0;
	localparam int C2_PIN1_EN = 7;
	localparam int C2_PIN2_EN = 6;
	localparam int C2_PULSE = 5;
	localparam int C2_PWM = 4;
	localparam int C2_CLK_HI = 3;
	localparam int C2_CLK_LO = 2;
	localparam int C2_EDGE2 = 1;
	localparam int C2_EXT_EDGE = 0;
	localparam int F_CAP1 = 7;
	localparam int F_CMP1 = 6;
	localparam int F_OVF = 5;
	localparam int F_CAP2 = 4;
	localparam int F_CMP2 = 3;
	localparam int F_DIS = 2;

	// -----------------------------------------------------------------
	// Values
	// -----------------------------------------------------------------
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [15:0] CNT_RESET = 16'hfffc;
	localparam logic [15:0] CNT_TOP = 16'hffff;
	localparam logic [15:0] CMP_RESET = 16'h8000;
	localparam logic [1:0] CLK_DIV4 = 2'h0;
	localparam logic [1:0] CLK_DIV2 = 2'h1;
	localparam logic [1:0] CLK_DIV8 = 2'h2;
	localparam logic [1:0] CLK_EXT = 2'h3;
	localparam logic [2:0] DIV2_MASK = 3'h1;
	localparam logic [2:0] DIV4_MASK = 3'h3;
	localparam logic [2:0] DIV8_MASK = 3'h7;
	localparam logic [7:0] FLAGS_WMASK = 8'h04;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic [7:0] wdata;
	} tmr_acc_s;

	typedef struct packed {
		logic cap1;
		logic cap2;
		logic ext_clk;
	} tmr_pins_s;
endpackage

//--- tmr_edge.sv
// Edge detector for one synchronous timer input pin.
// Assumes the pin is already synchronous to MCLK.
`timescale 1ns/1ps
`default_nettype none
module tmr_edge (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Pin and edge choice
	input wire logic pin,
	input wire logic rising,
	// Event
	output logic hit
);
	logic prev_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= pin;
		end
	end

	assign hit = rising ? (pin & ~prev_reg) : (~pin & prev_reg);
endmodule // tmr_edge
`default_nettype wire

//--- tmr_tick.sv
// Counter clock enable: prescaler of MCLK or selected edge of the external clock.
// Assumes the external clock is synchronous and slow compared with MCLK.
`timescale 1ns/1ps
`default_nettype none
module tmr_tick import tmr_pkg::*; #(
	parameter bit HAS_EXT = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Control
	input wire logic freeze,
	input wire logic [1:0] sel,
	input wire logic ext_rise,
	input wire logic ext_pin,
	// Tick
	output logic tick
);
	logic [2:0] pre_reg;
	logic ext_hit;
	logic [2:0] mask;

	tmr_edge u_ext (.clk(clk), .nrst(nrst), .pin(ext_pin), .rising(ext_rise), .hit(ext_hit));

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pre_reg <= 3'h0;
		end else if (!freeze) begin
			pre_reg <= pre_reg + 3'h1;
		end
	end

	always_comb begin
		unique case (sel)
			CLK_DIV4: mask = DIV4_MASK;
			CLK_DIV2: mask = DIV2_MASK;
			CLK_DIV8: mask = DIV8_MASK;
			CLK_EXT: mask = DIV8_MASK;
		endcase
	end

	// Without the pin the external setting yields no tick at all.
	assign tick = freeze ? 1'b0 :
		(sel == CLK_EXT) ? (HAS_EXT & ext_hit) :
		((pre_reg & mask) == mask);
endmodule // tmr_tick
`default_nettype wire

//--- tmr_top.sv
// Sixteen-bit capture/compare timer with APB register access.
// Assumes pins are synchronous to MCLK; registers are byte wide in the low data lane.
`timescale 1ns/1ps
`default_nettype none
// Function
// - All events share one interrupt, gated by enables and the CPU mask.
// - Every enabled, unmasked timer interrupt wakes from wait; none wakes from halt.
// - Control one bits 7,6,5 enable capture, compare and overflow interrupts.
// - Force bits copy level bits to outputs unless the disable bit is set.
// - Level two drives output two on match; output one in pulse/PWM modes.
// - Control one bit 1 picks capture one edge, one means rising.
// - Level one goes to output one on compare one match.
// - Pin enable one only connects output one; compare one keeps running.
// - Pin enable two only connects output two; compare two keeps running.
// - Single pulse mode fires one pulse on capture one edge.
// - PWM gives repeating waveform, pulse by compare one, period by two.
// - Clock select: 00 div4, 01 div2, 10 div8, 11 external.
// - Without external pin, external setting stops the counter.
// - Control two bit 1 picks capture two edge, one means rising.
// - Control two bit 0 picks external clock edge, one means rising.
// - Capture one flag set by capture or PWM period; status read then low byte.
// - Compare one flag on match outside pulse and PWM modes; cleared by status read then low byte access.
// - Capture two flag on capture; cleared by status read then low byte access.
// - Compare two flag on match outside PWM mode; cleared by status read then low byte access.
// - Overflow flag on wrap; cleared by status read then counter low access.
// - Disable bit freezes prescaler and counter and disables outputs.
// - Compare high write suppresses that compare until low byte written.
// - In PWM a compare two match reloads counter with FFFC.
module tmr_top import tmr_pkg::*; #(
	parameter bit HAS_EXT = 1'b1
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic NRST,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Pins
	input wire logic CAPTURE_INPUT_ONE,
	input wire logic CAPTURE_INPUT_TWO,
	input wire logic EXTERNAL_CLOCK_INPUT,
	output logic COMPARE_OUTPUT_ONE,
	output logic COMPARE_OUTPUT_TWO,
	output logic OUTPUT_ONE_PIN_ENABLE,
	output logic OUTPUT_TWO_PIN_ENABLE,
	// CPU side
	input wire logic CPU_IRQ_MASK,
	input wire logic CPU_IN_WAIT,
	output logic TIMER_IRQ,
	output logic WAKE_FROM_WAIT
);
	// -----------------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------------
	logic [7:0] ctl_one_reg, ctl_two_reg;
	logic [4:0] flag_reg;
	logic dis_reg;
	logic [4:0] armed_reg;
	logic [15:0] cnt_reg, cmp1_reg, cmp2_reg, cap1_reg, cap2_reg;
	logic [7:0] cmp1_hi_reg, cmp2_hi_reg;
	logic [15:0] cmp1_act_reg, cmp2_act_reg;
	logic inh1_reg, inh2_reg;
	logic out1_reg, out2_reg;
	logic [7:0] cap1_lo_latch_reg;
	logic pulse_run_reg;
	tmr_acc_s acc;
	tmr_pins_s pins;
	logic take, addr_ok, tick, cap1_hit, cap2_hit;
	logic pwm_on, pulse_on, match1, match2, wrap;
	logic [4:0] set_ev, clr_ev;
	logic [7:0] rd_byte;

	assign pins = '{cap1: CAPTURE_INPUT_ONE, cap2: CAPTURE_INPUT_TWO,
		ext_clk: EXTERNAL_CLOCK_INPUT};
	assign acc = '{addr: PADDR[9:2], wr: PWRITE, wdata: PWDATA[7:0]};
	assign take = PSEL & PENABLE & PREADY;
	assign pwm_on = ctl_two_reg[C2_PWM];
	assign pulse_on = ctl_two_reg[C2_PULSE] & ~pwm_on;

	function automatic logic is_acc(input tmr_acc_s a, input logic [7:0] idx);
		return a.addr == idx;
	endfunction

	assign addr_ok = (PADDR[1:0] == 2'h0) && (PADDR[31:10] == 22'h0) &&
		(((acc.addr >= IDX_CTL_TWO) && (acc.addr <= IDX_CMP2_LO)) || is_acc(acc, IDX_WAKE));

	// -----------------------------------------------------------------
	// Clock and input events
	// -----------------------------------------------------------------
	tmr_tick #(.HAS_EXT(HAS_EXT)) u_tick (
		.clk(MCLK), .nrst(NRST), .freeze(dis_reg),
		.sel({ctl_two_reg[C2_CLK_HI], ctl_two_reg[C2_CLK_LO]}),
		.ext_rise(ctl_two_reg[C2_EXT_EDGE]), .ext_pin(pins.ext_clk), .tick(tick));
	tmr_edge u_cap1 (.clk(MCLK), .nrst(NRST), .pin(pins.cap1),
		.rising(ctl_one_reg[C1_EDGE1]), .hit(cap1_hit));
	tmr_edge u_cap2 (.clk(MCLK), .nrst(NRST), .pin(pins.cap2),
		.rising(ctl_two_reg[C2_EDGE2]), .hit(cap2_hit));

	assign match1 = tick && !inh1_reg && (cnt_reg == cmp1_act_reg);
	assign match2 = tick && !inh2_reg && (cnt_reg == cmp2_act_reg);
	assign wrap = tick && (cnt_reg == CNT_TOP);

	// -----------------------------------------------------------------
	// APB slave: one wait-free access phase
	// -----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0;
		end else begin
			PREADY <= PSEL & ~PENABLE;
			PSLVERR <= PSEL & ~PENABLE & ~addr_ok;
			PRDATA <= (PSEL & ~PENABLE & ~PWRITE & addr_ok) ? {24'h0, rd_byte} : 32'h0;
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		unique case (acc.addr)
			IDX_CTL_TWO: rd_byte = ctl_two_reg;
			IDX_CTL_ONE: rd_byte = ctl_one_reg;
			IDX_FLAGS: rd_byte = {flag_reg, dis_reg, 2'b00};
			IDX_CAP1_HI: rd_byte = cap1_reg[15:8];
			IDX_CAP1_LO: rd_byte = cap1_reg[7:0];
			IDX_CMP1_HI: rd_byte = cmp1_reg[15:8];
			IDX_CMP1_LO: rd_byte = cmp1_reg[7:0];
			IDX_CNT_HI, IDX_ACNT_HI: rd_byte = cnt_reg[15:8];
			IDX_CNT_LO, IDX_ACNT_LO: rd_byte = cnt_reg[7:0];
			IDX_CAP2_HI: rd_byte = cap2_reg[15:8];
			IDX_CAP2_LO: rd_byte = cap2_reg[7:0];
			IDX_CMP2_HI: rd_byte = cmp2_reg[15:8];
			IDX_CMP2_LO: rd_byte = cmp2_reg[7:0];
			default: rd_byte = 8'h00;
		endcase
	end

	// -----------------------------------------------------------------
	// Control registers
	// -----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			ctl_one_reg <= CTL_RESET;
			ctl_two_reg <= CTL_RESET;
			dis_reg <= 1'b0;
		end else if (take && acc.wr) begin
			if (is_acc(acc, IDX_CTL_ONE)) ctl_one_reg <= acc.wdata;
			if (is_acc(acc, IDX_CTL_TWO)) ctl_two_reg <= acc.wdata;
			// Low flag bits are read-only zero; software keeps them clear.
			if (is_acc(acc, IDX_FLAGS)) dis_reg <= |(acc.wdata & FLAGS_WMASK);
		end
	end

	// -----------------------------------------------------------------
	// Compare values: high write inhibits until low write; in PWM the
	// active copies load only at the end of a period to avoid spikes.
	// -----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			cmp1_reg <= CMP_RESET;
			cmp2_reg <= CMP_RESET;
			cmp1_act_reg <= CMP_RESET;
			cmp2_act_reg <= CMP_RESET;
			inh1_reg <= 1'b0;
			inh2_reg <= 1'b0;
		end else begin
			if (take && acc.wr && is_acc(acc, IDX_CMP1_HI)) begin
				cmp1_reg[15:8] <= acc.wdata;
				inh1_reg <= 1'b1;
			end
			if (take && acc.wr && is_acc(acc, IDX_CMP1_LO)) begin
				cmp1_reg[7:0] <= acc.wdata;
				inh1_reg <= 1'b0;
			end
			if (take && acc.wr && is_acc(acc, IDX_CMP2_HI)) begin
				cmp2_reg[15:8] <= acc.wdata;
				inh2_reg <= 1'b1;
			end
			if (take && acc.wr && is_acc(acc, IDX_CMP2_LO)) begin
				cmp2_reg[7:0] <= acc.wdata;
				inh2_reg <= 1'b0;
			end
			if (!pwm_on || match2) begin
				cmp1_act_reg <= cmp1_reg;
				cmp2_act_reg <= cmp2_reg;
			end
		end
	end

	// -----------------------------------------------------------------
	// Counter and captures
	// -----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			cnt_reg <= CNT_RESET;
		end else if (take && acc.wr && (is_acc(acc, IDX_CNT_LO) || is_acc(acc, IDX_ACNT_LO))) begin
			cnt_reg <= CNT_RESET;
		end else if (pulse_on && cap1_hit && !dis_reg) begin
			cnt_reg <= CNT_RESET;
		end else if (pwm_on && match2) begin
			cnt_reg <= CNT_RESET;
		end else if (tick) begin
			cnt_reg <= cnt_reg + 16'h1;
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			cap1_reg <= 16'h0;
			cap2_reg <= 16'h0;
		end else begin
			if (cap1_hit && !pwm_on) cap1_reg <= cnt_reg;
			if (cap2_hit) cap2_reg <= cnt_reg;
		end
	end

	// -----------------------------------------------------------------
	// Flags: a set in the same cycle as the clearing access wins.
	// -----------------------------------------------------------------
	assign set_ev[4] = (cap1_hit && !pwm_on) || (pwm_on && match2);
	assign set_ev[3] = match1 && !pwm_on && !pulse_on;
	assign set_ev[2] = wrap;
	assign set_ev[1] = cap2_hit;
	assign set_ev[0] = match2 && !pwm_on;
	assign clr_ev[4] = take && is_acc(acc, IDX_CAP1_LO);
	assign clr_ev[3] = take && is_acc(acc, IDX_CMP1_LO);
	assign clr_ev[2] = take && is_acc(acc, IDX_CNT_LO);
	assign clr_ev[1] = take && is_acc(acc, IDX_CAP2_LO);
	assign clr_ev[0] = take && is_acc(acc, IDX_CMP2_LO);

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			flag_reg <= 5'h0;
			armed_reg <= 5'h0;
		end else begin
			for (int i = 0; i < 5; i++) begin
				if (set_ev[i]) begin
					flag_reg[i] <= 1'b1;
				end else if (clr_ev[i] && armed_reg[i]) begin
					flag_reg[i] <= 1'b0;
				end
				if (take && !acc.wr && is_acc(acc, IDX_FLAGS)) begin
					armed_reg[i] <= flag_reg[i];
				end else if (clr_ev[i]) begin
					armed_reg[i] <= 1'b0;
				end
			end
		end
	end

	// -----------------------------------------------------------------
	// Compare outputs
	// -----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			out1_reg <= 1'b0;
			out2_reg <= 1'b0;
			pulse_run_reg <= 1'b0;
		end else if (!dis_reg) begin
			if (pwm_on) begin
				if (match2) out1_reg <= ctl_one_reg[C1_LVL2];
				else if (match1) out1_reg <= ctl_one_reg[C1_LVL1];
			end else if (pulse_on) begin
				if (cap1_hit) begin
					out1_reg <= ctl_one_reg[C1_LVL2];
					pulse_run_reg <= 1'b1;
				end else if (match1 && pulse_run_reg) begin
					out1_reg <= ctl_one_reg[C1_LVL1];
					pulse_run_reg <= 1'b0;
				end
			end else if (match1) begin
				out1_reg <= ctl_one_reg[C1_LVL1];
			end
			if (ctl_one_reg[C1_FORCE1]) out1_reg <= ctl_one_reg[C1_LVL1];
			if (!pwm_on && !pulse_on && match2) out2_reg <= ctl_one_reg[C1_LVL2];
			if (ctl_one_reg[C1_FORCE2]) out2_reg <= ctl_one_reg[C1_LVL2];
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			COMPARE_OUTPUT_ONE <= 1'b0;
			COMPARE_OUTPUT_TWO <= 1'b0;
			OUTPUT_ONE_PIN_ENABLE <= 1'b0;
			OUTPUT_TWO_PIN_ENABLE <= 1'b0;
		end else begin
			// Pin enables only hand the pins over; compare logic runs regardless.
			COMPARE_OUTPUT_ONE <= out1_reg;
			COMPARE_OUTPUT_TWO <= out2_reg;
			OUTPUT_ONE_PIN_ENABLE <= ctl_two_reg[C2_PIN1_EN] & ~dis_reg;
			OUTPUT_TWO_PIN_ENABLE <= ctl_two_reg[C2_PIN2_EN] & ~dis_reg;
		end
	end

	// -----------------------------------------------------------------
	// Interrupt request and wake
	// -----------------------------------------------------------------
	logic irq_src;
	assign irq_src = (ctl_one_reg[C1_CAP_IE] & (flag_reg[4] | flag_reg[1])) |
		(ctl_one_reg[C1_CMP_IE] & (flag_reg[3] | flag_reg[0])) |
		(ctl_one_reg[C1_OVF_IE] & flag_reg[2]);

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			TIMER_IRQ <= 1'b0;
			WAKE_FROM_WAIT <= 1'b0;
		end else begin
			TIMER_IRQ <= irq_src & ~CPU_IRQ_MASK;
			// Halt stops MCLK here, so no event can reach the halted core.
			WAKE_FROM_WAIT <= irq_src & ~CPU_IRQ_MASK & CPU_IN_WAIT;
		end
	end

	AST_OVF_SET: assert property (@(posedge MCLK) disable iff (!NRST)
		wrap |=> flag_reg[2]) else $error("overflow flag not set after wrap");
	AST_IRQ_GATE: assert property (@(posedge MCLK) disable iff (!NRST)
		TIMER_IRQ |-> $past(irq_src) && !$past(CPU_IRQ_MASK)) else $error("irq without cause");
	AST_WAKE: assert property (@(posedge MCLK) disable iff (!NRST)
		WAKE_FROM_WAIT |-> TIMER_IRQ) else $error("wake without irq");
	AST_DIS_PINS: assert property (@(posedge MCLK) disable iff (!NRST)
		dis_reg |=> !OUTPUT_ONE_PIN_ENABLE && !OUTPUT_TWO_PIN_ENABLE) else $error("pins on while disabled");
	AST_DIS_FREEZE: assert property (@(posedge MCLK) disable iff (!NRST)
		(dis_reg && !take) |=> $stable(cnt_reg)) else $error("counter moved while disabled");
	AST_PWM_RELOAD: assert property (@(posedge MCLK) disable iff (!NRST)
		(pwm_on && match2 && !take) |=> cnt_reg == CNT_RESET) else $error("no pwm reload");
	AST_INHIBIT: assert property (@(posedge MCLK) disable iff (!NRST)
		(inh1_reg && !flag_reg[3]) |=> !flag_reg[3]) else $error("compare active while inhibited");
	AST_FORCE1: assert property (@(posedge MCLK) disable iff (!NRST)
		(ctl_one_reg[C1_FORCE1] && !dis_reg) |=> ##1 COMPARE_OUTPUT_ONE == $past(ctl_one_reg[C1_LVL1], 2))
		else $error("force one not applied");
	AST_CAP2_FLAG: assert property (@(posedge MCLK) disable iff (!NRST)
		cap2_hit |=> flag_reg[1]) else $error("capture two flag missing");
endmodule // tmr_top
`default_nettype wire

//--- tmr_pin_model.sv
// Far-side pin model: drives both capture pins and the external clock pin,
// and counts rising edges seen on compare output one.
// Assumes the timer samples its pins on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model (
	// Clock
	input wire logic clk,
	// Pins seen from the far side
	input wire logic cmp1,
	output logic cap1,
	output logic cap2,
	output logic ext_clk,
	// Edge count of compare output one
	output var int rises
);
	logic last = 1'b0;

	// The clock pin idles low between uses, as a gated source would.
	initial begin
		cap1 = 1'b0;
		cap2 = 1'b0;
		ext_clk = 1'b0;
		rises = 0;
	end

	always @(posedge clk) begin
		last <= cmp1;
		if (cmp1 === 1'b1 && last === 1'b0) begin
			rises <= rises + 1;
		end
	end

	// Pin 0 and 1 are the capture pins, 2 the clock pin; the level is held
	// long enough for the design's edge detector and flag register.
	task automatic drive(input int pin, input logic v);
		@(posedge clk);
		if (pin == 0) begin
			cap1 <= v;
		end else if (pin == 1) begin
			cap2 <= v;
		end else begin
			ext_clk <= v;
		end
		repeat (4) @(posedge clk);
	endtask
endmodule // tmr_pin_model
`default_nettype wire

//--- tmr_top_test.sv
// Self-checking bench for the capture/compare timer: APB register tasks and
// pin scenarios run in one sequence.
// Assumes tmr_pkg, the design files and tmr_pin_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
	compares++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("BAD t=%0t got %h exp %h", $time, (g), (e)); \
	end \
end
module tmr_top_test;
	import tmr_pkg::*;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready, pslverr, err, mask = 1'b1, in_wait = 1'b0;
	logic cap1, cap2, ext, oc1, oc2, en1, en2, irq, wake;
	logic [7:0] q, a;
	int fail_count = 0;
	int compares = 0;
	int rises, n0;
	logic [1:0] sl[3] = '{CLK_DIV4, CLK_DIV2, CLK_DIV8};
	int dv[3] = '{20, 40, 10};
	logic [7:0] ectl[2] = '{IDX_CTL_ONE, IDX_CTL_TWO};
	logic [7:0] elo[2] = '{IDX_CAP1_LO, IDX_CAP2_LO};
	int eflag[2] = '{F_CAP1, F_CAP2};

	tmr_top dut_u (.MCLK(mclk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.CAPTURE_INPUT_ONE(cap1), .CAPTURE_INPUT_TWO(cap2), .EXTERNAL_CLOCK_INPUT(ext),
		.COMPARE_OUTPUT_ONE(oc1), .COMPARE_OUTPUT_TWO(oc2), .OUTPUT_ONE_PIN_ENABLE(en1),
		.OUTPUT_TWO_PIN_ENABLE(en2), .CPU_IRQ_MASK(mask), .CPU_IN_WAIT(in_wait),
		.TIMER_IRQ(irq), .WAKE_FROM_WAIT(wake));
	tmr_pin_model ptn_u (.clk(mclk), .cmp1(oc1), .cap1(cap1), .cap2(cap2), .ext_clk(ext),
		.rises(rises));

	always #5 mclk = ~mclk;

	// -----------------------------------------------------------------
	// Bus tasks
	// -----------------------------------------------------------------
	// Read data and the error flag are taken at the edge that sees pready.
	task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {22'h0, i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer.
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		q = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		acc(1'b1, i, d);
	endtask
	task automatic rd(input logic [7:0] i);
		acc(1'b0, i, 8'h00);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// The whole sequence needs under a thousand cycles; this is ample margin.
	initial begin
		#200000;
		fail_count++;
		close_out();
	end

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	initial begin
		cyc(2);
		nrst <= 1'b1;
		rd(IDX_CTL_ONE);
		`CHK(q, CTL_RESET)
		rd(IDX_CMP2_HI);
		`CHK(q, CMP_RESET[15:8])
		rd(IDX_FLAGS);
		`CHK(q[2:0], 3'b000)
		acc(1'b0, 8'h70, 8'h00);
		`CHK(err, 1'b1)
		// Two reads 80 cycles apart; prescaler phase allows one tick of slack.
		for (int k = 0; k < 3; k++) begin
			wr(IDX_CTL_TWO, {4'h0, sl[k], 2'b00});
			rd(IDX_CNT_LO);
			a = q;
			cyc(77);
			rd(IDX_CNT_LO);
			`CHK(8'(q - a) inside {[dv[k] - 1 : dv[k] + 1]}, 1'b1)
		end
		// A lone rising edge counts only when the rising edge is selected.
		for (int k = 0; k < 2; k++) begin
			wr(IDX_CTL_TWO, {4'h0, CLK_EXT, 1'b0, k[0]});
			rd(IDX_CNT_LO);
			a = q;
			ptn_u.drive(2, 1'b1);
			rd(IDX_CNT_LO);
			`CHK(8'(q - a), 8'(k))
			ptn_u.drive(2, 1'b0);
		end
		for (int c = 0; c < 2; c++) begin
			wr(ectl[c], 8'h02);
			ptn_u.drive(c, 1'b1);
			rd(IDX_FLAGS);
			`CHK(q[eflag[c]], 1'b1)
			rd(elo[c]);
			ptn_u.drive(c, 1'b0);
			rd(IDX_FLAGS);
			`CHK(q[eflag[c]], 1'b0)
			wr(ectl[c], 8'h00);
			ptn_u.drive(c, 1'b1);
			ptn_u.drive(c, 1'b0);
			rd(IDX_FLAGS);
			`CHK(q[eflag[c]], 1'b1)
			rd(elo[c]);
		end
		wr(IDX_CTL_TWO, 8'hc4);
		wr(IDX_FLAGS, 8'h04);
		rd(IDX_CNT_LO);
		a = q;
		cyc(20);
		rd(IDX_CNT_LO);
		`CHK(q, a)
		`CHK({en1, en2}, 2'b00)
		wr(IDX_FLAGS, 8'h00);
		mask <= 1'b0;
		in_wait <= 1'b1;
		wr(IDX_CTL_ONE, 8'h20);
		rd(IDX_FLAGS);
		wr(IDX_CNT_LO, 8'h00);
		cyc(20);
		`CHK({irq, wake}, 2'b11)
		mask <= 1'b1;
		cyc(3);
		`CHK(irq, 1'b0)
		rd(IDX_FLAGS);
		rd(IDX_ACNT_LO);
		rd(IDX_FLAGS);
		`CHK(q[F_OVF], 1'b1)
		rd(IDX_CNT_LO);
		rd(IDX_FLAGS);
		`CHK(q[F_OVF], 1'b0)
		in_wait <= 1'b0;
		wr(IDX_CTL_ONE, 8'h05);
		wr(IDX_CMP1_HI, 8'h00);
		wr(IDX_CMP1_LO, 8'h04);
		wr(IDX_CMP2_HI, 8'h00);
		wr(IDX_CMP2_LO, 8'h04);
		wr(IDX_CNT_LO, 8'h00);
		cyc(30);
		`CHK({oc1, oc2, en1, en2}, 4'hf)
		rd(IDX_FLAGS);
		`CHK({q[F_CMP1], q[F_CMP2]}, 2'b11)
		rd(IDX_CMP1_LO);
		rd(IDX_FLAGS);
		rd(IDX_CMP2_LO);
		rd(IDX_FLAGS);
		`CHK({q[F_CMP1], q[F_CMP2]}, 2'b00)
		// Compare one is left half-written while its pin is released.
		wr(IDX_CTL_ONE, 8'h00);
		wr(IDX_CTL_TWO, 8'h04);
		wr(IDX_CMP1_HI, 8'h00);
		wr(IDX_CNT_LO, 8'h00);
		cyc(30);
		rd(IDX_FLAGS);
		`CHK({q[F_CMP1], q[F_CMP2], en1, en2}, 4'b0100)
		wr(IDX_CMP1_LO, 8'h04);
		wr(IDX_CTL_TWO, 8'hc4);
		cyc(4);
		`CHK({oc1, oc2}, 2'b10)
		wr(IDX_CTL_ONE, 8'h1c);
		cyc(4);
		`CHK({oc1, oc2}, 2'b01)
		wr(IDX_CMP1_LO, 8'h01);
		wr(IDX_CTL_ONE, 8'h04);
		wr(IDX_CTL_TWO, 8'h94);
		// The counter is past compare two here; restart it so periods begin at once.
		wr(IDX_CNT_LO, 8'h00);
		n0 = rises;
		cyc(200);
		`CHK((rises - n0) inside {[8:13]}, 1'b1)
		rd(IDX_FLAGS);
		`CHK(q[F_CAP1], 1'b1)
		wr(IDX_CTL_TWO, 8'ha4);
		wr(IDX_CTL_ONE, 8'h08);
		wr(IDX_CTL_ONE, 8'h06);
		cyc(3);
		`CHK(oc1, 1'b0)
		ptn_u.drive(0, 1'b1);
		`CHK(oc1, 1'b1)
		cyc(20);
		`CHK(oc1, 1'b0)
		close_out();
	end
endmodule // tmr_top_test
`default_nettype wire
